// [design/remap_cmd_pkg.sv]
package remap_cmd_pkg;
    localparam logic [11:0] GCMD_OFFSET = 12'h018;
    localparam logic [11:0] GSTS_OFFSET = 12'h01C;
    localparam logic [11:0] ROOT_ADDR_LO_OFFSET = 12'h020;
    localparam logic [11:0] ROOT_ADDR_HI_OFFSET = 12'h024;
    localparam logic [11:0] FLOG_ADDR_LO_OFFSET = 12'h058;
    localparam logic [11:0] FLOG_ADDR_HI_OFFSET = 12'h05C;
    localparam logic [11:0] ACTIVE_ROOT_LO_OFFSET = 12'h080;
    localparam logic [11:0] ACTIVE_FLOG_LO_OFFSET = 12'h084;
    localparam int XLATE_EN_BIT = 31;
    localparam int ROOT_LATCH_BIT = 30;
    localparam int FLOG_LATCH_BIT = 29;
    localparam int AFL_EN_BIT = 28;
    localparam logic [31:0] ONE_SHOT_MASK = 32'h96FFFFFF;
    localparam logic [31:0] GSTS_RESET = 32'h00000000;
    localparam logic [31:0] CMD_READ_VALUE = 32'h00000000;
    localparam logic [63:0] PTR_RESET = 64'h0000000000000000;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_t;

    typedef struct packed {
        logic translation_enable_status;
        logic root_pointer_status;
        logic fault_log_pointer_status;
        logic advanced_fault_log_status;
    } gsts_t;
endpackage : remap_cmd_pkg

// [design/remap_global_command_port.sv]
// Register access over APB was chosen for this implementation.
module remap_global_command_port (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // DMA traffic
    input wire logic dma_txn_active,
    input wire logic dma_queue_empty,
    // Remapping controls
    output logic remap_enable,
    output logic advanced_fault_log_on,
    output logic [63:0] active_root_pointer,
    output logic [63:0] active_fault_log_pointer
);
    import remap_cmd_pkg::*;

    typedef enum logic [2:0] {
        XL_IDLE = 3'b001,
        XL_DRAIN = 3'b010,
        XL_SWITCH = 3'b100
    } xl_state_t;

    xl_state_t xl_state_reg;
    apb_req_t req;
    gsts_t status_reg;
    logic [63:0] root_addr_reg;
    logic [63:0] flog_addr_reg;
    logic xl_target_reg;
    logic wr_fire;
    logic gcmd_wr;
    logic root_pend_reg;
    logic flog_pend_reg;

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign pready = 1'b1;
    assign wr_fire = psel && penable && req.write;
    assign gcmd_wr = wr_fire && (req.addr == GCMD_OFFSET);

    // Pointer source registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            root_addr_reg <= PTR_RESET;
            flog_addr_reg <= PTR_RESET;
        end else if (wr_fire) begin
            if (req.addr == ROOT_ADDR_LO_OFFSET) begin
                root_addr_reg[31:0] <= req.wdata;
            end else if (req.addr == ROOT_ADDR_HI_OFFSET) begin
                root_addr_reg[63:32] <= req.wdata;
            end else if (req.addr == FLOG_ADDR_LO_OFFSET) begin
                flog_addr_reg[31:0] <= req.wdata;
            end else if (req.addr == FLOG_ADDR_HI_OFFSET) begin
                flog_addr_reg[63:32] <= req.wdata;
            end
        end
    end

    // Root and fault log pointer latch, status one cycle after load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_root_pointer <= PTR_RESET;
            active_fault_log_pointer <= PTR_RESET;
        end else begin
            if (gcmd_wr && req.wdata[ROOT_LATCH_BIT]) begin
                active_root_pointer <= root_addr_reg;
            end
            if (gcmd_wr && req.wdata[FLOG_LATCH_BIT]) begin
                active_fault_log_pointer <= flog_addr_reg;
            end
        end
    end

    // Status bits: set after effect, pointer statuses clear on a new latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= GSTS_RESET[3:0];
        end else begin
            if (gcmd_wr && req.wdata[ROOT_LATCH_BIT]) begin
                status_reg.root_pointer_status <= 1'b0;
            end else if (root_pend_reg) begin
                status_reg.root_pointer_status <= 1'b1;
            end
            if (gcmd_wr && req.wdata[FLOG_LATCH_BIT]) begin
                status_reg.fault_log_pointer_status <= 1'b0;
            end else if (flog_pend_reg) begin
                status_reg.fault_log_pointer_status <= 1'b1;
            end
            status_reg.advanced_fault_log_status <= advanced_fault_log_on;
            if (xl_state_reg == XL_SWITCH && !dma_txn_active) begin
                status_reg.translation_enable_status <= xl_target_reg;
            end
        end
    end

    // Latch commands, one cycle old
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            root_pend_reg <= 1'b0;
            flog_pend_reg <= 1'b0;
        end else begin
            root_pend_reg <= gcmd_wr && req.wdata[ROOT_LATCH_BIT];
            flog_pend_reg <= gcmd_wr && req.wdata[FLOG_LATCH_BIT];
        end
    end

    // Advanced fault log enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            advanced_fault_log_on <= 1'b0;
        end else if (gcmd_wr) begin
            advanced_fault_log_on <= req.wdata[AFL_EN_BIT];
        end
    end

    // Translation enable sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xl_state_reg <= XL_IDLE;
            xl_target_reg <= 1'b0;
            remap_enable <= 1'b0;
        end else begin
            case (xl_state_reg)
                XL_IDLE: begin
                    if (gcmd_wr && req.wdata[XLATE_EN_BIT] != remap_enable) begin
                        xl_target_reg <= req.wdata[XLATE_EN_BIT];
                        xl_state_reg <= XL_DRAIN;
                    end
                end
                XL_DRAIN: begin
                    if (dma_queue_empty) begin
                        xl_state_reg <= XL_SWITCH;
                    end
                end
                XL_SWITCH: begin
                    if (!dma_txn_active) begin
                        remap_enable <= xl_target_reg;
                        xl_state_reg <= XL_IDLE;
                    end
                end
                default: begin
                    xl_state_reg <= XL_IDLE;
                end
            endcase
        end
    end

    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == GCMD_OFFSET) begin
                prdata <= CMD_READ_VALUE;
            end else if (paddr == GSTS_OFFSET) begin
                // Each status bit sits at its command bit's position
                prdata <= {status_reg.translation_enable_status, status_reg.root_pointer_status,
                    status_reg.fault_log_pointer_status, status_reg.advanced_fault_log_status,
                    28'h0000000};
            end else if (paddr == ROOT_ADDR_LO_OFFSET) begin
                prdata <= root_addr_reg[31:0];
            end else if (paddr == ROOT_ADDR_HI_OFFSET) begin
                prdata <= root_addr_reg[63:32];
            end else if (paddr == FLOG_ADDR_LO_OFFSET) begin
                prdata <= flog_addr_reg[31:0];
            end else if (paddr == FLOG_ADDR_HI_OFFSET) begin
                prdata <= flog_addr_reg[63:32];
            end else if (paddr == ACTIVE_ROOT_LO_OFFSET) begin
                prdata <= active_root_pointer[31:0];
            end else if (paddr == ACTIVE_FLOG_LO_OFFSET) begin
                prdata <= active_fault_log_pointer[31:0];
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    assign pslverr = 1'b0;

    xl_status_a: assert property (@(posedge pclk) disable iff (!presetn)
        (xl_state_reg == XL_SWITCH && !dma_txn_active) |=> status_reg.translation_enable_status == remap_enable)
        else $error("translation status does not follow enable");
    xl_boundary_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dma_txn_active && $past(dma_txn_active)) |-> remap_enable == $past(remap_enable))
        else $error("remap switched during a transaction");
    xl_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
        (xl_state_reg == XL_DRAIN && !dma_queue_empty) |=> xl_state_reg == XL_DRAIN)
        else $error("enable left drain with queued traffic");
    cmd_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == GCMD_OFFSET) |=> prdata == 32'h00000000)
        else $error("command register read not zero");
    root_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (gcmd_wr && pwdata[ROOT_LATCH_BIT]) |=> active_root_pointer == $past(root_addr_reg)
        ##1 status_reg.root_pointer_status)
        else $error("root pointer latch or status wrong");
    latch_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (gcmd_wr && !pwdata[ROOT_LATCH_BIT] && !pwdata[FLOG_LATCH_BIT]) |=> $stable(active_root_pointer)
        && $stable(active_fault_log_pointer))
        else $error("zero latch write changed a pointer");
    flog_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (gcmd_wr && pwdata[FLOG_LATCH_BIT]) |=> !status_reg.fault_log_pointer_status
        && active_fault_log_pointer == $past(flog_addr_reg) ##1 status_reg.fault_log_pointer_status)
        else $error("fault log latch or status wrong");
    afl_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        gcmd_wr |=> advanced_fault_log_on == $past(pwdata[AFL_EN_BIT])
        ##1 status_reg.advanced_fault_log_status == $past(advanced_fault_log_on))
        else $error("advanced fault log enable wrong");
endmodule : remap_global_command_port

// [sim/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import remap_cmd_pkg::*;
    typedef struct packed {logic [31:0] exp; logic [31:0] mask;} rd_note_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, dma_txn_active = 1'b0, dma_queue_empty = 1'b1;
    logic remap_enable, advanced_fault_log_on;
    logic [63:0] active_root_pointer, active_fault_log_pointer, rp, fp;
    logic [31:0] seed = 32'hDAF4875F;
    rd_note_t notes[$];
    rd_note_t note;
    int fails = 0, n_tests = 0, cyc = 0;

    always #2 pclk = ~pclk;

    remap_global_command_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_txn_active(dma_txn_active), .dma_queue_empty(dma_queue_empty),
        .remap_enable(remap_enable), .advanced_fault_log_on(advanced_fault_log_on),
        .active_root_pointer(active_root_pointer), .active_fault_log_pointer(active_fault_log_pointer));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Software read-modify-write of one command field
    function automatic logic [31:0] cmd_word(input logic [31:0] sts, input int pos, input logic v);
        return (sts & ONE_SHOT_MASK & ~(32'h00000001 << pos)) | (32'(v) << pos);
    endfunction : cmd_word

    task summarize();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{exp: e, mask: m});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task wait_en(input logic v);
        int n;
        n = 0;
        while (remap_enable !== v && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : wait_en

    // Read data checked against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (notes.size() == 0) chk(64'h1, 64'h0, "unexpected read");
            else begin
                note = notes.pop_front();
                chk({32'h0, prdata & note.mask}, {32'h0, note.exp}, "read data");
            end
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({62'h0, remap_enable, advanced_fault_log_on}, 64'h0, "reset levels");
        rd(GSTS_OFFSET, GSTS_RESET, 32'hFFFFFFFF);
        rd(GCMD_OFFSET, CMD_READ_VALUE, 32'hFFFFFFFF);
        rd(12'h100, 32'h0, 32'hFFFFFFFF);
        rp = {rnd(), rnd()};
        fp = {rnd(), rnd()};
        wr(ROOT_ADDR_LO_OFFSET, rp[31:0]);
        wr(ROOT_ADDR_HI_OFFSET, rp[63:32]);
        wr(GCMD_OFFSET, cmd_word(GSTS_RESET, ROOT_LATCH_BIT, 1'b1));
        // Cache invalidation after a latch lives outside this block
        #1;
        chk(active_root_pointer, rp, "root pointer load");
        rd(GSTS_OFFSET, 32'h40000000, 32'h40000000);
        rd(ACTIVE_ROOT_LO_OFFSET, rp[31:0], 32'hFFFFFFFF);
        wr(FLOG_ADDR_LO_OFFSET, fp[31:0]);
        wr(FLOG_ADDR_HI_OFFSET, fp[63:32]);
        wr(GCMD_OFFSET, cmd_word(32'h40000000, FLOG_LATCH_BIT, 1'b1));
        #1;
        chk(active_fault_log_pointer, fp, "fault log pointer load");
        rd(GSTS_OFFSET, 32'h20000000, 32'h20000000);
        rd(ACTIVE_FLOG_LO_OFFSET, fp[31:0], 32'hFFFFFFFF);
        wr(ROOT_ADDR_LO_OFFSET, ~rp[31:0]);
        wr(FLOG_ADDR_LO_OFFSET, ~fp[31:0]);
        wr(GCMD_OFFSET, cmd_word(32'h60000000, AFL_EN_BIT, 1'b1));
        #1;
        chk(active_root_pointer, rp, "zero root latch");
        chk(active_fault_log_pointer, fp, "zero fault latch");
        chk(64'(advanced_fault_log_on), 64'h1, "advanced log on");
        rd(GSTS_OFFSET, 32'h10000000, 32'h10000000);
        // Enable held off by queued and in-flight traffic
        @(posedge pclk);
        dma_queue_empty <= 1'b0;
        dma_txn_active <= 1'b1;
        wr(GCMD_OFFSET, cmd_word(32'h70000000, XLATE_EN_BIT, 1'b1));
        repeat (10) @(posedge pclk);
        #1;
        chk(64'(remap_enable), 64'h0, "enable before drain");
        rd(GSTS_OFFSET, 32'h0, 32'h80000000);
        dma_queue_empty <= 1'b1;
        repeat (10) @(posedge pclk);
        #1;
        chk(64'(remap_enable), 64'h0, "enable inside transaction");
        @(posedge pclk);
        dma_txn_active <= 1'b0;
        wait_en(1'b1);
        chk(64'(remap_enable), 64'h1, "enable after drain");
        rd(GSTS_OFFSET, 32'h80000000, 32'h80000000);
        // Root relatch while active, same tables as before
        wr(ROOT_ADDR_LO_OFFSET, rp[31:0]);
        wr(GCMD_OFFSET, cmd_word(32'hF0000000, ROOT_LATCH_BIT, 1'b1));
        #1;
        chk(active_root_pointer, rp, "root relatch while active");
        chk(64'(remap_enable), 64'h1, "enable kept over relatch");
        rd(GSTS_OFFSET, 32'hC0000000, 32'hC0000000);
        wr(GCMD_OFFSET, cmd_word(32'hF0000000, XLATE_EN_BIT, 1'b0));
        wait_en(1'b0);
        chk(64'(remap_enable), 64'h0, "disable");
        rd(GSTS_OFFSET, 32'h0, 32'h80000000);
        wr(GCMD_OFFSET, cmd_word(32'h70000000, AFL_EN_BIT, 1'b0));
        #1;
        chk(64'(advanced_fault_log_on), 64'h0, "advanced log off");
        summarize();
    end
endmodule : tb
